/* hw/mtcu_top.sv */
// PWM update path, interrupt gating and commutation timer registers
`timescale 1ns/100ps
module mtcu_top #(
	parameter int CNT_W = 12,
	parameter int REP_W = 8
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic        i_global_mask,
	input  wire logic        i_zero_cross,
	input  wire logic        i_ratio_inc,
	input  wire logic        i_ratio_dec,
	input  wire logic        i_cur_limit,
	input  wire logic        i_emergency,
	input  wire logic        i_demag_end,
	input  wire logic        i_commutate,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_irq_update,
	output logic             o_irq_ratio,
	output logic             o_irq_event,
	output logic             o_update,
	output logic [15:0]      o_act_u,
	output logic [15:0]      o_act_v,
	output logic [15:0]      o_act_w
);
	typedef struct packed {
		logic [7:0]       tim;
		logic [7:0]       timl;
		logic [7:0]       zprv;
		logic [7:0]       zreg;
		logic [7:0]       comp;
		logic [7:0]       dreg;
		logic [7:0]       wght;
		logic [7:0]       prsr;
		logic [7:0]       imr;
		logic [7:0]       isr;
		logic             speed_err;
		logic [7:0]       ctrl;
		logic [7:0]       rep;
		logic [7:0]       pcr;
		logic [15:0]      pre0;
		logic [15:0]      preu;
		logic [15:0]      prev;
		logic [15:0]      prew;
		logic [15:0]      act0;
		// Active copies taken at forced transfers only
		logic [REP_W-1:0] act_rep;
		logic [7:0]       act_pcr;
		logic [CNT_W-1:0] cnt;
		logic             down;
		logic [3:0]       psc;
		// Set by a high capture read, cleared by the low read
		logic             cap_block;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		logic             irq_u;
		logic             irq_r;
		logic             irq_e;
		logic             upd;
		logic [15:0]      actu;
		logic [15:0]      actv;
		logic [15:0]      actw;
	} mtcu_st_t;

	mtcu_st_t st_q;
	mtcu_st_t st_d;
	logic     rep_expire;
	logic     wrap;
	logic     run;
	logic     cke_rise;
	logic     resync;
	logic     wr;
	logic     rd;
	logic [7:0] wdat;
	logic [REP_W-1:0] rep_reload;

	initial begin
		if (CNT_W < 8 || CNT_W > 16) $error("counter width unsupported");
		if (REP_W != 8) $error("repetition width must be 8");
	end

	// Taken on the first access cycle; the ready pulse blocks a repeat
	assign wr   = i_psel && i_penable && i_pwrite && !st_q.pready;
	assign rd   = i_psel && i_penable && !i_pwrite && !st_q.pready;
	// Byte-wide registers use the low lane only
	assign wdat = i_pwdata[7:0];
	assign run  = st_q.ctrl[mtcu_pkg::CTL_CKE] && !st_q.ctrl[mtcu_pkg::CTL_HLT];
	// Of the enable writes, only a zero-to-one edge forces a transfer
	assign cke_rise = wr && (i_paddr == mtcu_pkg::OFF_CTRL)
		&& wdat[mtcu_pkg::CTL_CKE] && !st_q.ctrl[mtcu_pkg::CTL_CKE];
	assign resync = wr && (i_paddr == mtcu_pkg::OFF_ISR)
		&& (wdat == mtcu_pkg::RESYNC_VAL);
	// Overflow at top or underflow at zero, one prescaled tick
	// A new prescale value waits for the next forced transfer
	assign wrap = run && (st_q.psc >= st_q.act_pcr[3:0])
		&& (st_q.down ? (st_q.cnt == '0)
		: (st_q.cnt >= st_q.act0[CNT_W-1:0]));

	// Expiry reloads from the active copy; a forced load takes the new value
	assign rep_reload = (cke_rise || resync) ? st_q.rep[REP_W-1:0]
		: st_q.act_rep;

	mtcu_rep_cnt #(.W(REP_W)) u_rep (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_run    (run),
		.i_force  (cke_rise || resync),
		.i_wrap   (wrap),
		.i_reload (rep_reload),
		.o_expire (rep_expire)
	);

	always_comb begin
		logic        upd_ev;
		logic        tick;
		logic [15:0] prod;
		logic [7:0]  flags;
		logic [7:0]  ev;
		logic        se_set;
		st_d    = st_q;
		upd_ev  = cke_rise || resync || rep_expire;
		tick    = run && (st_q.psc >= st_q.act_pcr[3:0]);
		prod    = 16'h0000;
		flags   = st_q.isr;
		ev      = 8'h00;
		se_set  = 1'b0;
		// Bus answer and update strobe last one cycle
		st_d.pready  = 1'b0;
		st_d.pslverr = 1'b0;
		st_d.upd     = 1'b0;
		// PWM counter and prescaler
		st_d.psc = tick ? 4'h0 : (run ? st_q.psc + 4'h1 : 4'h0);
		// hold at zero when clock off
		if (!st_q.ctrl[mtcu_pkg::CTL_CKE] || resync) begin
			st_d.cnt  = '0;
			st_d.down = 1'b0;
			st_d.psc  = 4'h0;
		end else if (tick) begin
			if (st_q.act_pcr[mtcu_pkg::CTL_CMS]) begin
				if (!st_q.down && st_q.cnt >= st_q.act0[CNT_W-1:0]) begin
					st_d.down = 1'b1;
					st_d.cnt  = st_q.cnt - 1'b1;
				end else if (st_q.down && st_q.cnt == '0) begin
					st_d.down = 1'b0;
					st_d.cnt  = st_q.cnt + 1'b1;
				end else begin
					st_d.cnt = st_q.down ? st_q.cnt - 1'b1
						: st_q.cnt + 1'b1;
				end
			end else begin
				// edge mode wraps once per cycle
				st_d.cnt  = (st_q.cnt >= st_q.act0[CNT_W-1:0]) ? '0
					: st_q.cnt + 1'b1;
				st_d.down = 1'b0;
			end
		end
		// compare transfer on enable, resync or repetition expiry; prescale and repetition on enable or resync only
		if (upd_ev) begin
			st_d.act0 = st_q.pre0;
			st_d.actu = st_q.preu;
			st_d.actv = st_q.prev;
			st_d.actw = st_q.prew;
			st_d.upd  = 1'b1;
			if (cke_rise || resync) begin
				st_d.act_rep = st_q.rep[REP_W-1:0];
				st_d.act_pcr = st_q.pcr;
			end
		end
		// Commutation timer; halt freezes it
		if (run) begin
			if (st_q.ctrl[mtcu_pkg::CTL_SPD]) begin
				{st_d.tim, st_d.timl} = {st_q.tim, st_q.timl} + 16'h0001;
			end else begin
				st_d.tim = st_q.tim + 8'h01;
			end
			if (st_q.ctrl[mtcu_pkg::CTL_SPD] && st_q.tim == st_q.dreg) begin
				se_set = 1'b1;
			end
			if (i_ratio_inc && st_q.prsr[3:0] != 4'hf) begin
				st_d.prsr[3:0] = st_q.prsr[3:0] + 4'h1;
			end else if (i_ratio_dec && st_q.prsr[3:0] != 4'h0) begin
				st_d.prsr[3:0] = st_q.prsr[3:0] - 4'h1;
			end
			if (i_zero_cross && !st_q.ctrl[mtcu_pkg::CTL_SPD]) begin
				st_d.zprv = st_q.zreg;
				st_d.zreg = st_q.tim;
				// weighted next commutation
				// Product takes the captures as they stood before the shift
				if (st_q.ctrl[mtcu_pkg::CTL_AUTOSW]) begin
					prod = st_q.ctrl[mtcu_pkg::CTL_CAPSEL]
						? st_q.zprv * st_q.wght : st_q.zreg * st_q.wght;
					st_d.comp = prod[15:8];
				end
			end
			// Event pins count only while the block runs
			ev[mtcu_pkg::ISR_RP] = i_ratio_inc;
			ev[mtcu_pkg::ISR_RM] = i_ratio_dec;
			// current limit only in voltage mode
			ev[mtcu_pkg::ISR_CL] = i_cur_limit
				&& !st_q.ctrl[mtcu_pkg::CTL_VOC];
			ev[mtcu_pkg::ISR_EM] = i_emergency;
			ev[mtcu_pkg::ISR_ZC] = i_zero_cross;
			ev[mtcu_pkg::ISR_DM] = i_demag_end;
			ev[mtcu_pkg::ISR_CC] = i_commutate;
		end
		ev[mtcu_pkg::ISR_PU] = upd_ev;
		// Register writes
		// Software writes override the count of the same cycle
		if (wr) begin
			unique case (i_paddr)
				mtcu_pkg::OFF_TIM:  st_d.tim  = wdat;
				mtcu_pkg::OFF_TIML: st_d.timl = wdat;
				mtcu_pkg::OFF_ZPRV: st_d.zprv = wdat;
				mtcu_pkg::OFF_ZREG: st_d.zreg = wdat;
				mtcu_pkg::OFF_COMP: st_d.comp = wdat;
				mtcu_pkg::OFF_DREG: st_d.dreg = wdat;
				mtcu_pkg::OFF_WGHT: st_d.wght = wdat;
				mtcu_pkg::OFF_PRSR: st_d.prsr = wdat;
				mtcu_pkg::OFF_IMR:  st_d.imr  = wdat;
				mtcu_pkg::OFF_ISR: begin
					if (resync) begin
						flags = st_q.isr;
					end else if (st_q.ctrl[mtcu_pkg::CTL_AUTOSW]) begin
						flags = st_q.isr & wdat;
					end else begin
						flags = wdat;
					end
					// Resync leaves the speed error alone
					if (!resync && !i_pwdata[mtcu_pkg::ISR_SE]) begin
						st_d.speed_err = 1'b0;
					end
				end
				mtcu_pkg::OFF_CTRL: st_d.ctrl = wdat;
				mtcu_pkg::OFF_REP:  st_d.rep  = wdat;
				mtcu_pkg::OFF_PCR:  st_d.pcr  = wdat;
				// Compares arrive whole, so no half value can transfer
				mtcu_pkg::OFF_CMP0: st_d.pre0 = i_pwdata[15:0];
				mtcu_pkg::OFF_CMPU: st_d.preu = i_pwdata[15:0];
				mtcu_pkg::OFF_CMPV: st_d.prev = i_pwdata[15:0];
				mtcu_pkg::OFF_CMPW: st_d.prew = i_pwdata[15:0];
				default: st_d.pslverr = 1'b1;
			endcase
		end
		// Hardware set wins over software clear
		st_d.isr = flags | ev;
		if (se_set) st_d.speed_err = 1'b1;
		// Read data stands until the next read
		if (rd) begin
			st_d.prdata = 32'h0000_0000;
			unique case (i_paddr)
				mtcu_pkg::OFF_TIM: begin
					st_d.prdata[7:0] = st_q.tim;
					if (st_q.ctrl[mtcu_pkg::CTL_SPD] && !st_q.cap_block) begin
						st_d.zreg = st_q.tim;
						st_d.zprv = st_q.timl;
					end
				end
				mtcu_pkg::OFF_TIML: st_d.prdata[7:0] = st_q.timl;
				mtcu_pkg::OFF_ZPRV: begin
					st_d.prdata[7:0] = st_q.zprv;
					st_d.cap_block   = 1'b0;
				end
				mtcu_pkg::OFF_ZREG: begin
					st_d.prdata[7:0] = st_q.zreg;
					if (st_q.ctrl[mtcu_pkg::CTL_SPD]) st_d.cap_block = 1'b1;
				end
				mtcu_pkg::OFF_COMP: st_d.prdata[7:0] = st_q.comp;
				mtcu_pkg::OFF_DREG: st_d.prdata[7:0] = st_q.dreg;
				mtcu_pkg::OFF_WGHT: st_d.prdata[7:0] = st_q.wght;
				mtcu_pkg::OFF_PRSR: st_d.prdata[7:0] = st_q.prsr;
				mtcu_pkg::OFF_IMR:  st_d.prdata[7:0] = st_q.imr;
				mtcu_pkg::OFF_ISR:  st_d.prdata[8:0] = {st_q.speed_err, st_q.isr};
				mtcu_pkg::OFF_CTRL: st_d.prdata[7:0] = st_q.ctrl;
				mtcu_pkg::OFF_REP:  st_d.prdata[7:0] = st_q.rep;
				mtcu_pkg::OFF_PCR:  st_d.prdata[7:0] = st_q.pcr;
				// Compare reads return the preload, not the active value
				mtcu_pkg::OFF_CMP0: st_d.prdata[15:0] = st_q.pre0;
				mtcu_pkg::OFF_CMPU: st_d.prdata[15:0] = st_q.preu;
				mtcu_pkg::OFF_CMPV: st_d.prdata[15:0] = st_q.prev;
				mtcu_pkg::OFF_CMPW: st_d.prdata[15:0] = st_q.prew;
				mtcu_pkg::OFF_ACT0: st_d.prdata[15:0] = st_q.act0;
				mtcu_pkg::OFF_CNT:  st_d.prdata[CNT_W-1:0] = st_q.cnt;
				default: st_d.pslverr = 1'b1;
			endcase
		end
		if (rd || wr) st_d.pready = 1'b1;
		// Flags of this edge feed the irqs so both rise together
		// mask and global gate per vector
		// update irq follows update flag in the same edge
		st_d.irq_u = !i_global_mask && st_d.isr[mtcu_pkg::ISR_PU]
			&& st_q.imr[mtcu_pkg::ISR_PU];
		st_d.irq_r = !i_global_mask && st_q.imr[mtcu_pkg::IMR_RI]
			&& (st_d.isr[mtcu_pkg::ISR_RP] || st_d.isr[mtcu_pkg::ISR_RM]);
		st_d.irq_e = !i_global_mask && (|(st_d.isr[4:0] & st_q.imr[4:0])
			|| (st_d.speed_err && st_q.imr[mtcu_pkg::IMR_SE]));
	end

	// Synchronous reset clears every flop, the outputs included
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs are taken straight from the state flops
	assign o_prdata     = st_q.prdata;
	assign o_pready     = st_q.pready;
	assign o_pslverr    = st_q.pslverr;
	assign o_irq_update = st_q.irq_u;
	assign o_irq_ratio  = st_q.irq_r;
	assign o_irq_event  = st_q.irq_e;
	assign o_update     = st_q.upd;
	assign o_act_u      = st_q.actu;
	assign o_act_v      = st_q.actv;
	assign o_act_w      = st_q.actw;
endmodule

/* shared/mtcu_pkg.sv */
// Constants for the motor update and commutation timer block
package mtcu_pkg;
	localparam logic [7:0] ADDR_W = 8'h08;
	// Word byte offsets
	localparam logic [7:0] OFF_TIM    = 8'h00;
	localparam logic [7:0] OFF_TIML   = 8'h04;
	localparam logic [7:0] OFF_ZPRV   = 8'h08;
	localparam logic [7:0] OFF_ZREG   = 8'h0c;
	localparam logic [7:0] OFF_COMP   = 8'h10;
	localparam logic [7:0] OFF_DREG   = 8'h14;
	localparam logic [7:0] OFF_WGHT   = 8'h18;
	localparam logic [7:0] OFF_PRSR   = 8'h1c;
	localparam logic [7:0] OFF_IMR    = 8'h20;
	localparam logic [7:0] OFF_ISR    = 8'h24;
	localparam logic [7:0] OFF_CTRL   = 8'h28;
	localparam logic [7:0] OFF_REP    = 8'h2c;
	localparam logic [7:0] OFF_PCR    = 8'h30;
	localparam logic [7:0] OFF_CMP0   = 8'h34;
	localparam logic [7:0] OFF_CMPU   = 8'h38;
	localparam logic [7:0] OFF_CMPV   = 8'h3c;
	localparam logic [7:0] OFF_CMPW   = 8'h40;
	localparam logic [7:0] OFF_ACT0   = 8'h44;
	localparam logic [7:0] OFF_CNT    = 8'h48;
	// Status bits
	localparam int ISR_PU  = 7;
	localparam int ISR_RP  = 6;
	localparam int ISR_RM  = 5;
	localparam int ISR_CL  = 4;
	localparam int ISR_EM  = 3;
	localparam int ISR_ZC  = 2;
	localparam int ISR_DM  = 1;
	localparam int ISR_CC  = 0;
	// Speed error clear bit of a status write, read back at the same place
	localparam int ISR_SE  = 8;
	// Mask bits (bit 6 is speed error)
	localparam int IMR_SE  = 6;
	localparam int IMR_RI  = 5;
	// Control bits
	localparam int CTL_CKE = 0;
	localparam int CTL_AUTOSW = 1;
	localparam int CTL_VOC = 2;
	localparam int CTL_CAPSEL = 3;
	localparam int CTL_SPD = 4;
	localparam int CTL_CMS = 5;
	localparam int CTL_HLT = 6;
	localparam logic [7:0] RESYNC_VAL = 8'hff;
	localparam logic [7:0] RST8       = 8'h00;
	localparam logic [15:0] CMP_RST   = 16'h0000;
endpackage

/* hw/mtcu_rep_cnt.sv */
// Auto-reload repetition down-counter that paces compare updates
`timescale 1ns/100ps
module mtcu_rep_cnt #(
	parameter int W = 8
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_run,
	input  wire logic         i_force,
	input  wire logic         i_wrap,
	input  wire logic [W-1:0] i_reload,
	output logic              o_expire
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	initial begin
		if (W < 2) $error("repetition width too small");
	end

	assign o_expire = i_run && i_wrap && (cnt_q == '0);

	always_comb begin
		cnt_d = cnt_q;
		// reload after expiry, N wraps per transfer
		// A value of zero transfers at every wrap
		if (i_force || o_expire) begin
			cnt_d = (i_reload == '0) ? '0 : i_reload - 1'b1;
		end else if (i_run && i_wrap) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

/* tb/mtcu_properties.sv */
// Bus handshake, update and interrupt gating checks for the motor block
`timescale 1ns/100ps
module mtcu_checker (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic        i_global_mask,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_update,
	input wire logic        o_irq_update,
	input wire logic        o_irq_ratio,
	input wire logic        o_irq_event
);
	logic acc;
	assign acc = i_psel & i_penable & ~o_pready;
	default clocking dc @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	ready_wait_a: assert property (acc |=> o_pready)
		else $error("no ready one cycle after access");
	ready_pulse_a: assert property (o_pready |=> !o_pready)
		else $error("ready held longer than one cycle");
	ready_cause_a: assert property (o_pready |-> $past(acc))
		else $error("ready without an access");
	unmapped_err_a: assert property (acc && i_paddr > 8'h48 |=> o_pslverr)
		else $error("no error on unmapped address");
	mapped_ok_a: assert property (acc && i_paddr <= 8'h48 |=> !o_pslverr)
		else $error("error on mapped address");
	resync_upd_a: assert property (acc && i_pwrite && i_paddr == 8'h24 &&
		i_pwdata[7:0] == 8'hff |-> ##[1:3] o_update)
		else $error("no update after resync write");
	upd_pulse_a: assert property ((o_update ##1 o_update)
		|-> $past(acc && i_pwrite))
		else $error("back to back update without a bus write");
	global_gate_a: assert property (i_global_mask && $past(i_global_mask)
		|-> !(o_irq_update || o_irq_ratio || o_irq_event))
		else $error("interrupt while globally masked");
	reset_quiet_a: assert property (disable iff (1'b0)
		i_rst |=> !o_update && !o_pready && !o_irq_update)
		else $error("output active after reset edge");
	cover property (o_update);
	cover property (o_irq_ratio);
	cover property (o_pslverr);
endmodule
bind mtcu_top mtcu_checker chk_u (.i_clk, .i_rst, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .i_global_mask, .o_pready, .o_pslverr,
	.o_update, .o_irq_update, .o_irq_ratio, .o_irq_event);

/* tb/mtcu_motor_model.sv */
// Motor and gate driver side: turns bench requests into event pulses
`timescale 1ns/100ps
module mtcu_motor_model (
	input  wire logic       i_clk,
	input  wire logic [6:0] i_kick,
	output logic      [6:0] o_ev
);
	initial o_ev = 7'h00;
	always @(posedge i_clk) begin
		o_ev <= i_kick;
		if (i_kick[1] && i_kick[2])
			o_ev[2:1] <= 2'b00;
	end
endmodule

/* tb/motor_pwm_update_and_timer_tb.sv */
// Directed bench for the motor update block over its register bus
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
	err_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module motor_pwm_update_and_timer_tb;
	logic        i_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
	logic        i_pwrite = 1'b0, i_global_mask = 1'b0, se;
	logic [7:0]  i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata, q, p;
	logic [6:0]  kick = 7'h00, ev;
	logic        o_pready, o_pslverr, o_irq_update, o_irq_ratio;
	logic        o_irq_event, o_update;
	logic [15:0] o_act_u, o_act_v, o_act_w;
	int          err_count = 0, total_checks = 0, cyc = 0, t1, t2;
	always #10 i_clk = ~i_clk;
	mtcu_top dut_u (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .i_global_mask, .i_zero_cross(ev[0]), .i_ratio_inc(ev[1]),
		.i_ratio_dec(ev[2]), .i_cur_limit(ev[3]), .i_emergency(ev[4]),
		.i_demag_end(ev[5]), .i_commutate(ev[6]), .o_prdata, .o_pready,
		.o_pslverr, .o_irq_update, .o_irq_ratio, .o_irq_event, .o_update,
		.o_act_u, .o_act_v, .o_act_w);
	mtcu_motor_model mot_u (.i_clk, .i_kick(kick), .o_ev(ev));
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do @(posedge i_clk); while (o_pready !== 1'b1);
		q = o_prdata;
		se = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
		xf(1'b0, a, 32'h0);
		`CHK(n, e, q[7:0])
	endtask
	task automatic pk(input int i);
		@(posedge i_clk);
		kick <= 7'(1 << i);
		@(posedge i_clk);
		kick <= 7'h00;
		repeat (3) @(posedge i_clk);
	endtask
	task automatic wu(output int n);
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_update !== 1'b1);
	endtask
	// First two waits only align to the new update rhythm
	task automatic per(input logic [7:0] r, input logic [7:0] m, output int t);
		xf(1'b1, 8'h30, {24'h0, m});
		xf(1'b1, 8'h2c, {24'h0, r});
		xf(1'b1, 8'h24, 32'hff);
		wu(t);
		wu(t);
		wu(t);
	endtask
	task automatic t_rst;
		for (int a = 0; a <= 32; a += 4)
			rc(8'(a), 8'h00, "reset value");
		rc(8'h48, 8'h00, "idle count");
		xf(1'b0, 8'h4c, 32'h0);
		`CHK("unmapped error", 1'b1, se)
		$display("reset test done");
	endtask
	task automatic t_start;
		xf(1'b1, 8'h34, 32'h10);
		xf(1'b1, 8'h38, 32'h5);
		xf(1'b1, 8'h3c, 32'h6);
		xf(1'b1, 8'h40, 32'h7);
		xf(1'b1, 8'h20, 32'h80);
		xf(1'b1, 8'h2c, 32'h1);
		xf(1'b1, 8'h28, 32'h1);
		repeat (4) @(posedge i_clk);
		`CHK("active u", 16'h0005, o_act_u)
		`CHK("active v", 16'h0006, o_act_v)
		`CHK("active w", 16'h0007, o_act_w)
		rc(8'h24, 8'h80, "update flag");
		`CHK("update irq", 1'b1, o_irq_update)
		i_global_mask <= 1'b1;
		repeat (3) @(posedge i_clk);
		`CHK("masked irq", 1'b0, o_irq_update)
		i_global_mask <= 1'b0;
		$display("start test done");
	endtask
	task automatic t_rep;
		per(8'h01, 8'h00, t1);
		per(8'h03, 8'h00, t2);
		`CHK("edge interval", 3 * t1, t2)
		per(8'h02, 8'h20, t1);
		per(8'h04, 8'h20, t2);
		`CHK("center interval", 2 * t1, t2)
		wu(t1);
		`CHK("reload interval", t2, t1)
		$display("repetition test done");
	endtask
	task automatic t_flags;
		xf(1'b1, 8'h28, 32'h3);
		xf(1'b1, 8'h24, 32'h0);
		xf(1'b1, 8'h20, 32'hb0);
		pk(1);
		xf(1'b0, 8'h1c, 32'h0);
		`CHK("step up", 4'h1, q[3:0])
		`CHK("ratio irq", 1'b1, o_irq_ratio)
		xf(1'b1, 8'h24, 32'hff);
		xf(1'b0, 8'h24, 32'h0);
		`CHK("flags after resync", 7'h40, q[6:0])
		pk(2);
		xf(1'b0, 8'h1c, 32'h0);
		`CHK("step down", 4'h0, q[3:0])
		xf(1'b1, 8'h24, 32'h0);
		xf(1'b1, 8'h24, 32'h7f);
		xf(1'b0, 8'h24, 32'h0);
		`CHK("flags after ones", 7'h00, q[6:0])
		`CHK("ratio irq off", 1'b0, o_irq_ratio)
		pk(3);
		xf(1'b0, 8'h24, 32'h0);
		`CHK("limit voltage", 1'b1, q[4])
		`CHK("event irq", 1'b1, o_irq_event)
		xf(1'b1, 8'h24, 32'h0);
		xf(1'b1, 8'h28, 32'h7);
		pk(3);
		xf(1'b0, 8'h24, 32'h0);
		`CHK("limit current", 1'b0, q[4])
		$display("flag test done");
	endtask
	task automatic t_mul;
		xf(1'b1, 8'h18, 32'h40);
		for (int i = 0; i < 2; i++) begin
			xf(1'b1, 8'h28, i ? 32'hb : 32'h3);
			xf(1'b1, 8'h0c, 32'h80);
			xf(1'b1, 8'h08, 32'h40);
			pk(0);
			rc(8'h10, i ? 8'h10 : 8'h20, "next commutation");
		end
		$display("multiplier test done");
	endtask
	// Software capture of the timer pair and its read lock
	task automatic t_speed;
		xf(1'b1, 8'h28, 32'h11);
		xf(1'b0, 8'h00, 32'h0);
		p = q;
		rc(8'h0c, p[7:0], "speed capture");
		xf(1'b1, 8'h04, 32'h0);
		xf(1'b1, 8'h00, {24'h0, ~p[7:0]});
		xf(1'b0, 8'h00, 32'h0);
		rc(8'h0c, p[7:0], "capture locked");
		xf(1'b0, 8'h08, 32'h0);
		xf(1'b0, 8'h00, 32'h0);
		p = q;
		rc(8'h0c, p[7:0], "capture freed");
		$display("speed test done");
	endtask
	task automatic t_halt;
		xf(1'b1, 8'h28, 32'h43);
		xf(1'b0, 8'h48, 32'h0);
		p = q;
		pk(1);
		xf(1'b0, 8'h48, 32'h0);
		`CHK("frozen count", p, q)
		rc(8'h1c, 8'h00, "frozen step");
		xf(1'b1, 8'h28, 32'h0);
		rc(8'h48, 8'h00, "stopped count");
		$display("halt test done");
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			print_verdict;
		end
	end
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		t_rst;
		t_start;
		t_rep;
		t_flags;
		t_mul;
		t_speed;
		t_halt;
		print_verdict;
	end
endmodule
